/* File: bench/dsr_ctrl_props.sv */
/* Checker for dsr_ctrl: clamps, output mode, status output, restart policy.
 Sees the block's ports only; bound to every dsr_ctrl instance. */
`timescale 1ns/1ps
module dsr_ctrl_props
  import dsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Inputs watched
  input wire logic [dsr_pkg::VOLT_W-1:0] vf_volt_in,
  input wire logic [dsr_pkg::VOLT_W-1:0] rated_volt_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] vf_freq_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] base_freq_in,
  input wire logic [3:0] out_func_in,
  input wire logic [1:0] restart_mode_in,
  input wire logic run_pin_in,
  input wire logic fault_in,
  input wire logic fast_stop_in,
  input wire logic mains_loss_in,
  // Outputs watched
  input wire logic [dsr_pkg::VOLT_W-1:0] vf_volt_out,
  input wire logic [dsr_pkg::FREQ_W-1:0] vf_freq_out,
  input wire logic [dsr_pkg::FREQ_W-1:0] speed_out,
  input wire logic [dsr_pkg::OUT_W-1:0] aout_level_out,
  input wire logic analog_mode_out,
  input wire logic dout_out,
  input wire logic drive_en_out,
  input wire logic tripped_out,
  input wire logic [4:0] attempts_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Set once the run switch was seen open, or at once outside edge mode; a closed switch at power-up must not start
  logic armed_r;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) armed_r <= 1'b0;
    else if (!run_pin_in || restart_mode_in != RM_EDGE) armed_r <= 1'b1;
  a_volt_clamp: assert property ($past(rstn_in) && $stable(vf_volt_in) && $stable(rated_volt_in)
    |-> vf_volt_out == ((vf_volt_in > rated_volt_in) ? rated_volt_in : vf_volt_in))
    else $error("adjust voltage not clamped");
  a_freq_clamp: assert property ($past(rstn_in) && $stable(vf_freq_in) && $stable(base_freq_in)
    |-> vf_freq_out == ((vf_freq_in > base_freq_in) ? base_freq_in : vf_freq_in))
    else $error("adjust frequency not clamped");
  a_mode_flag: assert property ($past(rstn_in) && $stable(out_func_in)
    |-> analog_mode_out == (out_func_in >= OF_ANA_SPD)) else $error("output mode wrong");
  a_trip_out: assert property ($past(rstn_in) && $stable(out_func_in) && out_func_in == OF_TRIPPED
    |-> dout_out == $past(tripped_out)) else $error("tripped output wrong");
  a_health_out: assert property ($past(rstn_in) && $stable(out_func_in) && out_func_in == OF_HEALTHY
    |-> dout_out == !$past(tripped_out)) else $error("healthy output wrong");
  a_tries_cap: assert property (attempts_out <= AUTO_TRIES) else $error("too many tries");
  a_tries_step: assert property (attempts_out != $past(attempts_out) |-> attempts_out == 5'h00 ||
    attempts_out == $past(attempts_out) + 5'h01) else $error("attempt count jumped");
  a_level_run: assert property ((restart_mode_in == RM_LEVEL && run_pin_in && !fault_in &&
    !tripped_out && !fast_stop_in && !mains_loss_in)[*6] |-> drive_en_out)
    else $error("level mode not running");
  a_edge_hold: assert property (!armed_r |-> !drive_en_out) else $error("edge mode ran");
  a_aout_zero: assert property ($past(rstn_in) && $past(out_func_in) == OF_ANA_SPD &&
    $past(speed_out) == 16'h0000 |-> aout_level_out == 12'h000) else $error("aout not 0");
  // Main scenarios reached
  c_retry_end: cover property (attempts_out == AUTO_TRIES);
  c_edge_run: cover property (drive_en_out && restart_mode_in == RM_EDGE);
  c_digital: cover property (!analog_mode_out && dout_out);
endmodule : dsr_ctrl_props
bind dsr_ctrl dsr_ctrl_props u_props (.*);

/* File: bench/dsr_ctrl_tb_top.sv */
/* Self-checking bench for dsr_ctrl with the motor model.
 Inputs change on the falling edge; short restart wait of 20 cycles. */
`timescale 1ns/1ps
module dsr_ctrl_tb_top;
  import dsr_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] preset4_in, max_speed_in, min_speed_in, base_freq_in, decel2_time_in;
  logic [15:0] accel_time_in, decel_time_in, skip_band_in, skip_ctr_in, vf_freq_in;
  logic [15:0] rated_cur_in, demand_in, motor_cur_in, speed_out, vf_freq_out;
  logic [11:0] vf_volt_in, rated_volt_in, vf_volt_out, aout_level_out;
  logic [9:0] user_limit_in;
  logic [3:0] out_func_in;
  logic [1:0] restart_mode_in;
  logic [4:0] attempts_out;
  logic mains_loss_ramp_in, preset4_sel_in, run_pin_in, fast_stop_in, mains_loss_in;
  logic fault_in, keypad_reset_in, dout_out, analog_mode_out, drive_en_out, coast_out;
  logic tripped_out, close_sw;
  logic [7:0] exp_tab;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  dsr_ctrl #(.RESTART_WAIT(20)) dut (.*);
  dsr_motor motor (.speed_in(speed_out), .drive_en_in(drive_en_out), .coast_in(coast_out),
    .close_in(close_sw), .run_pin_out(run_pin_in), .cur_out(motor_cur_in));
  // Clock and a hang guard well above the planned run
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc_n
  task automatic do_reset(input logic [1:0] mode, input logic sw);
    rstn_in = 1'b0;
    restart_mode_in = mode;
    close_sw = sw;
    cyc_n(20);
    rstn_in = 1'b1;
  endtask : do_reset
  task automatic t_vf();
    vf_volt_in = 12'hfff;
    vf_freq_in = 16'hffff;
    cyc_n(3);
    chk(16'(vf_volt_out), 16'(rated_volt_in), "volt clamp");
    chk(vf_freq_out, base_freq_in, "freq clamp");
  endtask : t_vf
  task automatic t_outs();
    close_sw = 1'b1;
    cyc_n(8);
    chk(16'(drive_en_out), 16'h0001, "level run");
    for (int l = 0; l < 2; l++) begin
      user_limit_in = (l == 1) ? 10'h3e8 : 10'h000;
      exp_tab = (l == 1) ? 8'hc7 : 8'h37;
      for (int i = 0; i < 8; i++) begin
        out_func_in = 4'(i);
        cyc_n(3);
        chk(16'({analog_mode_out, dout_out}), 16'(exp_tab[i]), "digital out");
      end
    end
    out_func_in = OF_ANA_CUR;
    cyc_n(3);
    chk(16'({analog_mode_out, aout_level_out}), 16'h1000, "current level");
  endtask : t_outs
  task automatic t_coast();
    fast_stop_in = 1'b1;
    cyc_n(4);
    chk(16'(coast_out), 16'h0000, "ramp two used");
    decel2_time_in = 16'h0000;
    cyc_n(4);
    chk(16'(coast_out), 16'h0001, "coast");
    fast_stop_in = 1'b0;
    decel2_time_in = 16'h0032;
  endtask : t_coast
  task automatic t_auto();
    do_reset(RM_AUTO, 1'b1);
    cyc_n(8);
    fault_in = 1'b1;
    cyc_n(600);
    chk(16'(attempts_out), 16'h000f, "tries");
    fault_in = 1'b0;
    cyc_n(100);
    chk(16'(tripped_out), 16'h0001, "stays tripped");
    keypad_reset_in = 1'b1;
    cyc_n(2);
    keypad_reset_in = 1'b0;
    cyc_n(2);
    chk(16'(attempts_out), 16'h0000, "keypad clear");
    close_sw = 1'b0;
    cyc_n(5);
    close_sw = 1'b1;
    cyc_n(8);
    fault_in = 1'b1;
    cyc_n(3);
    fault_in = 1'b0;
    cyc_n(40);
    chk(16'({attempts_out, drive_en_out}), 16'h0003, "auto resume");
  endtask : t_auto
  task automatic t_edge();
    do_reset(RM_EDGE, 1'b1);
    cyc_n(40);
    chk(16'(drive_en_out), 16'h0000, "closed at power-up");
    close_sw = 1'b0;
    cyc_n(5);
    close_sw = 1'b1;
    cyc_n(8);
    chk(16'(drive_en_out), 16'h0001, "reclosed");
  endtask : t_edge
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {preset4_in, min_speed_in, skip_band_in, skip_ctr_in, demand_in} = '0;
    {max_speed_in, base_freq_in} = {16'h01f4, 16'h01f4};
    {decel2_time_in, accel_time_in, decel_time_in} = {3{16'h0032}};
    {vf_freq_in, rated_cur_in, vf_volt_in, rated_volt_in} = {16'h0064, 16'h0064, 12'h0c8, 12'h0e6};
    {user_limit_in, out_func_in} = {10'h000, OF_ANA_SPD};
    {mains_loss_ramp_in, preset4_sel_in, fast_stop_in, mains_loss_in} = 4'h0;
    {fault_in, keypad_reset_in} = 2'h0;
    do_reset(RM_LEVEL, 1'b0);
    cyc_n(2);
    chk({speed_out[14:0], analog_mode_out}, 16'h0001, "reset speed");
    chk(16'(attempts_out), 16'h0000, "reset count");
    t_vf();
    t_outs();
    t_coast();
    t_auto();
    t_edge();
    tally_and_finish();
  end
endmodule : dsr_ctrl_tb_top

/* File: bench/dsr_motor.sv */
/* Motor and run switch model facing dsr_ctrl.
 Current follows the driven speed; the switch follows the bench. */
`timescale 1ns/1ps
module dsr_motor
  import dsr_pkg::*;
(
  // Drive side
  input wire logic [dsr_pkg::FREQ_W-1:0] speed_in,
  input wire logic drive_en_in,
  input wire logic coast_in,
  // Operator side
  input wire logic close_in,
  output logic run_pin_out,
  output logic [dsr_pkg::CUR_W-1:0] cur_out
);
  // Operator reopens and recloses the switch to start in edge mode
  assign run_pin_out = close_in;
  // A coasting or idle motor draws nothing
  assign cur_out = (drive_en_in && !coast_in) ? speed_in : 16'h0000;
endmodule : dsr_motor

/* File: rtl/dsr_ctrl.sv */
/*
 Speed reference, fast-stop ramp, configurable output, V/F adjust point
 and terminal restart policy for a single-phase motor drive.
 Assumes settings and measurements are synchronous to clk_in; the run
 switch is a pin and is synchronised here.
*/
`timescale 1ns/1ps
module dsr_ctrl
  import dsr_pkg::*;
#(
  parameter longint RESTART_WAIT = RESTART_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Settings
  input wire logic [dsr_pkg::FREQ_W-1:0] preset4_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] max_speed_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] min_speed_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] base_freq_in,
  input wire logic [15:0] decel2_time_in,
  input wire logic [15:0] accel_time_in,
  input wire logic [15:0] decel_time_in,
  input wire logic [3:0] out_func_in,
  input wire logic [dsr_pkg::PCT_W-1:0] user_limit_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] skip_band_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] skip_ctr_in,
  input wire logic [dsr_pkg::VOLT_W-1:0] vf_volt_in,
  input wire logic [dsr_pkg::VOLT_W-1:0] rated_volt_in,
  input wire logic [dsr_pkg::FREQ_W-1:0] vf_freq_in,
  input wire logic [dsr_pkg::CUR_W-1:0] rated_cur_in,
  input wire logic [1:0] restart_mode_in,
  input wire logic mains_loss_ramp_in,
  // Demands and status
  input wire logic [dsr_pkg::FREQ_W-1:0] demand_in,
  input wire logic preset4_sel_in,
  input wire logic run_pin_in,
  input wire logic fast_stop_in,
  input wire logic mains_loss_in,
  input wire logic fault_in,
  input wire logic keypad_reset_in,
  input wire logic [dsr_pkg::CUR_W-1:0] motor_cur_in,
  // Outputs
  output logic [dsr_pkg::FREQ_W-1:0] speed_out,
  output logic [dsr_pkg::VOLT_W-1:0] vf_volt_out,
  output logic [dsr_pkg::FREQ_W-1:0] vf_freq_out,
  output logic [dsr_pkg::OUT_W-1:0] aout_level_out,
  output logic dout_out,
  output logic analog_mode_out,
  output logic drive_en_out,
  output logic coast_out,
  output logic tripped_out,
  output logic [4:0] attempts_out
);
  import dsr_pkg::*;

  // Clamp helper
  function automatic logic [FREQ_W-1:0] clampf(input logic [FREQ_W-1:0] v,
      input logic [FREQ_W-1:0] lo, input logic [FREQ_W-1:0] hi);
    clampf = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampf

  // Scale a value to OUT_W by a full-scale figure
  function automatic logic [OUT_W-1:0] scale(input logic [31:0] v,
      input logic [31:0] fs);
    logic [43:0] prod;
    prod = 44'(v) * 44'(4095);
    if (fs == 32'h0 || v >= fs) scale = 12'hfff;
    else scale = OUT_W'(prod / 44'(fs));
  endfunction : scale

  // Run pin synchroniser
  logic run_s1_r, run_s2_r, run_d_r;
  logic [1:0] fill_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_s1_r <= 1'b0;
      run_s2_r <= 1'b0;
      run_d_r <= 1'b0;
      fill_r <= 2'h0;
    end else begin
      run_s1_r <= run_pin_in;
      run_s2_r <= run_s1_r;
      run_d_r <= run_s2_r;
      if (fill_r != 2'h3) fill_r <= fill_r + 2'h1;
    end
  end
  // No edge until the pipe holds real pin samples: a switch closed at
  // power-up would otherwise look like a fresh closure
  wire run_rise = run_s2_r & ~run_d_r & (fill_r == 2'h3);

  // Settings clamping
  wire [FREQ_W-1:0] preset4 = clampf(preset4_in, 16'h0000, max_speed_in);
  wire [FREQ_W-1:0] skip_ctr = clampf(skip_ctr_in, min_speed_in, max_speed_in);
  wire [FREQ_W-1:0] vf_freq = clampf(vf_freq_in, 16'h0000, base_freq_in);
  wire [VOLT_W-1:0] vf_volt = (vf_volt_in > rated_volt_in) ? rated_volt_in : vf_volt_in;
  wire [15:0] decel2 = (decel2_time_in > DECEL2_MAX_DS) ? DECEL2_MAX_DS : decel2_time_in;

  // Skip band edges; half band either side of the centre
  wire [FREQ_W-1:0] half_band = skip_band_in >> 1;
  wire [FREQ_W-1:0] skip_lo = (skip_ctr > half_band) ? skip_ctr - half_band : 16'h0000;
  wire [FREQ_W-1:0] skip_hi = skip_ctr + half_band;
  wire [FREQ_W-1:0] raw_dem = preset4_sel_in ? preset4 : demand_in;
  wire in_band = (skip_band_in != 16'h0000) && raw_dem > skip_lo && raw_dem < skip_hi;

  // Restart state machine
  dsr_state_type state_r, state_nxt;
  logic [4:0] tries_r, tries_nxt;
  logic [35:0] wait_r, wait_nxt;
  logic armed_r, armed_nxt;
  logic en_r;
  logic [FREQ_W-1:0] ref_r, ref_nxt, spd_r, spd_nxt;
  wire stop_fast = fast_stop_in | (mains_loss_in & mains_loss_ramp_in);
  wire reenable = run_rise & (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    tries_nxt = tries_r;
    wait_nxt = wait_r;
    armed_nxt = armed_r;
    if (keypad_reset_in || reenable) tries_nxt = 5'h00;
    case (state_r)
      ST_IDLE: begin
        if (restart_mode_in == RM_EDGE) begin
          if (run_rise) armed_nxt = 1'b1;
          if (armed_r && run_s2_r && !fault_in) state_nxt = ST_RUN;
        end else if (run_s2_r && !fault_in) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_in) begin
          state_nxt = ST_TRIP;
          armed_nxt = 1'b0;
        end else if (!run_s2_r) begin
          state_nxt = ST_IDLE;
          armed_nxt = 1'b0;
        end
      end
      ST_TRIP: begin
        if (keypad_reset_in) begin
          state_nxt = ST_IDLE; // Edge mode then waits for reopen
        end else if (restart_mode_in == RM_AUTO && tries_r < AUTO_TRIES) begin
          state_nxt = ST_WAIT;
          wait_nxt = 36'h0;
        end // Else stays tripped
      end
      ST_WAIT: begin
        wait_nxt = wait_r + 36'h1;
        if (keypad_reset_in) begin
          state_nxt = ST_IDLE;
        end else if (wait_r >= 36'(RESTART_WAIT - 1)) begin
          tries_nxt = tries_r + 5'h01;
          state_nxt = (!fault_in && run_s2_r) ? ST_RUN : ST_TRIP;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Reference with skip hysteresis: hold previous edge while in band
  always_comb begin
    ref_nxt = raw_dem;
    if (in_band) ref_nxt = (ref_r >= skip_hi) ? skip_hi : skip_lo;
  end

  // Ramp tick divider
  logic [15:0] tick_cnt_r, acc_r;
  wire tick = (tick_cnt_r == 16'(TICK_CYC - 1));
  wire running = (state_r == ST_RUN);
  wire [15:0] down_time = stop_fast ? decel2 : decel_time_in;
  wire coast = stop_fast & (decel2 == 16'h0000);
  wire [FREQ_W-1:0] target = (running && !stop_fast) ? ref_r : 16'h0000;
  // Step by one 0.1 Hz each time the ms accumulator passes the per-step time
  wire up = target > spd_r;
  wire [31:0] step_ms = 32'(up ? accel_time_in : down_time) * 32'd100 /
                        32'(base_freq_in == 16'h0 ? 16'h1 : base_freq_in);
  always_comb begin
    spd_nxt = spd_r;
    if (coast) spd_nxt = 16'h0000;
    else if (tick && 32'(acc_r) >= step_ms && target != spd_r)
      spd_nxt = up ? spd_r + 16'h1 : spd_r - 16'h1;
  end

  // Sequential state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
      tries_r <= 5'h00;
      wait_r <= 36'h0;
      armed_r <= 1'b0;
      ref_r <= 16'h0000;
      spd_r <= 16'h0000;
      tick_cnt_r <= 16'h0000;
      acc_r <= 16'h0000;
      en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tries_r <= tries_nxt;
      wait_r <= wait_nxt;
      armed_r <= armed_nxt;
      ref_r <= ref_nxt;
      spd_r <= spd_nxt;
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h1;
      if (tick) acc_r <= (32'(acc_r) >= step_ms) ? 16'h0000 : acc_r + 16'h1;
      en_r <= running & ~coast;
    end
  end

  // Comparisons against the single user limit, 0.1 % units of full scale
  wire [31:0] spd_lim = 32'(max_speed_in) * 32'(user_limit_in) / 32'd1000;
  wire [31:0] cur_lim = 32'(rated_cur_in) * 32'(user_limit_in) / 32'd1000;
  wire spd_ge = 32'(spd_r) >= spd_lim;
  wire cur_ge = 32'(motor_cur_in) >= cur_lim;
  wire tripped = (state_r == ST_TRIP) | (state_r == ST_WAIT);
  wire at_speed = running & (spd_r == ref_r);
  logic cond;
  always_comb begin
    case (out_func_in)
      OF_ENABLED: cond = en_r;
      OF_HEALTHY: cond = ~tripped;
      OF_AT_SPEED: cond = at_speed;
      OF_TRIPPED: cond = tripped;
      OF_SPD_GE: cond = spd_ge;
      OF_CUR_GE: cond = cur_ge;
      OF_SPD_LT: cond = ~spd_ge;
      OF_CUR_LT: cond = ~cur_ge;
      default: cond = 1'b0;
    endcase
  end
  wire [OUT_W-1:0] ana_spd = scale(32'(spd_r), 32'(max_speed_in));
  wire [OUT_W-1:0] ana_cur = scale(32'(motor_cur_in), 32'(rated_cur_in) * 32'd2);
  wire analog = (out_func_in == OF_ANA_SPD) | (out_func_in == OF_ANA_CUR);

  // Registered outputs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dout_out <= 1'b0;
      aout_level_out <= 12'h000;
      analog_mode_out <= 1'b1;
      vf_volt_out <= 12'h000;
      vf_freq_out <= 16'h0000;
    end else begin
      dout_out <= ~analog & cond;
      aout_level_out <= (out_func_in == OF_ANA_CUR) ? ana_cur : (analog ? ana_spd : 12'h000);
      analog_mode_out <= analog;
      vf_volt_out <= vf_volt;
      vf_freq_out <= vf_freq;
    end
  end

  // Direct status
  assign speed_out = spd_r;
  assign drive_en_out = en_r;
  assign coast_out = coast;
  assign tripped_out = tripped;
  assign attempts_out = tries_r;
endmodule : dsr_ctrl

/* File: rtl/dsr_pkg.sv */
/*
 Package for the drive speed, output and restart control block: widths,
 reset values, mode codes and timing constants.
 Assumes a 20 MHz system clock.
*/
package dsr_pkg;
  // Widths of settings and measurements
  localparam int FREQ_W = 16;           // Speed in 0.1 Hz units
  localparam int VOLT_W = 12;           // Voltage in volts
  localparam int CUR_W = 16;            // Current in 0.01 A units
  localparam int PCT_W = 10;            // Percent in 0.1 % units
  localparam int OUT_W = 12;            // Analog output code width
  // Reset values
  localparam logic [FREQ_W-1:0] PRESET4_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] SKIP_CTR_RST = 16'h0000;
  localparam logic [FREQ_W-1:0] VF_FREQ_RST = 16'h0000;
  localparam logic [3:0] OUT_FUNC_RST = 4'h8;
  localparam logic [15:0] DECEL2_MAX_DS = 16'h00fa;  // 25.0 s in 0.1 s
  // Output function codes
  localparam logic [3:0] OF_ENABLED = 4'h0;
  localparam logic [3:0] OF_HEALTHY = 4'h1;
  localparam logic [3:0] OF_AT_SPEED = 4'h2;
  localparam logic [3:0] OF_TRIPPED = 4'h3;
  localparam logic [3:0] OF_SPD_GE = 4'h4;
  localparam logic [3:0] OF_CUR_GE = 4'h5;
  localparam logic [3:0] OF_SPD_LT = 4'h6;
  localparam logic [3:0] OF_CUR_LT = 4'h7;
  localparam logic [3:0] OF_ANA_SPD = 4'h8;
  localparam logic [3:0] OF_ANA_CUR = 4'h9;
  // Restart modes
  localparam logic [1:0] RM_EDGE = 2'h0;
  localparam logic [1:0] RM_LEVEL = 2'h1;
  localparam logic [1:0] RM_AUTO = 2'h2;
  localparam logic [4:0] AUTO_TRIES = 5'h0f;
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int RESTART_WAIT_S = 25;
  localparam longint RESTART_WAIT_CYC = longint'(RESTART_WAIT_S) * CLK_HZ;
  localparam int TICK_MS = 1;           // Ramp tick period
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Restart states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_WAIT} dsr_state_type;
endpackage : dsr_pkg
